// File: core/nvg_pkg.sv
package nvg_pkg;
    // Clock and timing
    localparam int CLK_HZ = 50_000_000;
    localparam int PWRT_MS = 64;
    localparam int PWRT_CYCLES = PWRT_MS * (CLK_HZ / 1000);
    localparam int SETUP_CYCLES = 2;
    localparam int WRITE_CYCLES = 64;
    // Register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_UNLOCK = 6'h04;
    localparam logic [5:0] OFS_ADDRL = 6'h08;
    localparam logic [5:0] OFS_ADDRH = 6'h0C;
    localparam logic [5:0] OFS_DATAL = 6'h10;
    localparam logic [5:0] OFS_DATAH = 6'h14;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h18;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h1C;
    // Control bit positions
    localparam int CTRL_RD = 0;
    localparam int CTRL_WR = 1;
    localparam int CTRL_WRITE_ENABLE = 2;
    localparam int CTRL_WERR = 3;
    localparam int CTRL_PSEL = 7;
    // Interrupt bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_DENY = 1;
    // Unlock keys, field masks and reset values
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
    localparam logic [7:0] ADDRH_MASK = 8'h1F;
    localparam logic [7:0] DATAH_MASK = 8'h3F;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [15:0] CNT_RST = 16'h0000;

    typedef struct packed {
        logic sel;
        logic err;
        logic en;
        logic wr;
        logic rd;
    } nvg_ctrl_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvg_prog_t;

    typedef enum {UNL_IDLE, UNL_GOT1, UNL_ARMED} nvg_unl_t;
endpackage

// File: core/nvg_guard.sv
`timescale 1ns/100ps
module nvg_guard #(
    parameter int PWRT_CNT = nvg_pkg::PWRT_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic por_i,
    input wire logic data_protect_fuse_i,
    input wire nvg_pkg::nvg_prog_t prog_i,
    output logic [7:0] prog_rdata_o,
    output logic prog_denied_o,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o
);
    import nvg_pkg::*;

    logic [7:0] mem [0:255];
    nvg_ctrl_t ctrl;
    nvg_unl_t unl;
    logic [7:0] addr_low;
    logic [7:0] addr_high;
    logic [7:0] data_low;
    logic [7:0] data_high;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [15:0] wr_cnt;
    logic [21:0] pwrt_cnt;
    logic pwrt_done;
    nvg_prog_t prog_s1;
    nvg_prog_t prog_s2;
    logic prog_req_d;
    logic fuse_s1;
    logic fuse_s2;
    logic acc;
    logic bus_wr;
    logic [7:0] wbyte;
    logic start_ok;
    logic wr_fire;
    logic prog_go;
    logic protect;

    // Bus access is taken on the edge where waitrequest is low
    assign acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    assign bus_wr = acc & avs_write_i & avs_byteenable_i[0];
    assign wbyte = avs_writedata_i[7:0];
    assign protect = ~fuse_s2;
    assign prog_go = prog_s2.req & ~prog_req_d;
    assign wr_fire = ctrl.wr & (wr_cnt == CNT_RST);

    // Write start qualified by enable, unlock and power-up timer
    assign start_ok = bus_wr && (avs_address_i == OFS_CTRL) && wbyte[CTRL_WR]
        && ctrl.en && wbyte[CTRL_WRITE_ENABLE]
        && (unl == UNL_ARMED)
        && pwrt_done
        && !ctrl.wr && !ctrl.sel;

    // Wait state: one cycle high, one cycle low per access
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
        end
    end

    // Read data mux, latched during the wait cycle
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i & avs_waitrequest_o) begin
            avs_readdata_o <= 32'h0000_0000;
            if (avs_address_i == OFS_CTRL) begin
                avs_readdata_o[7:0] <= {ctrl.sel, 3'h0, ctrl.err, ctrl.en, ctrl.wr, ctrl.rd};
            end else if (avs_address_i == OFS_ADDRL) begin
                avs_readdata_o[7:0] <= addr_low;
            end else if (avs_address_i == OFS_ADDRH) begin
                avs_readdata_o[7:0] <= addr_high;
            end else if (avs_address_i == OFS_DATAL) begin
                avs_readdata_o[7:0] <= data_low;
            end else if (avs_address_i == OFS_DATAH) begin
                avs_readdata_o[7:0] <= data_high;
            end else if (avs_address_i == OFS_IRQ_STAT) begin
                avs_readdata_o[1:0] <= irq_stat;
            end else if (avs_address_i == OFS_IRQ_MASK) begin
                avs_readdata_o[1:0] <= irq_mask;
            end
        end
    end

    // Unlock sequencer: the port keeps no value, only the sequence state
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            unl <= UNL_IDLE;
        end else if (acc) begin
            if (bus_wr && avs_address_i == OFS_UNLOCK && wbyte == UNLOCK_KEY1) begin
                unl <= UNL_GOT1;
            end else if (bus_wr && avs_address_i == OFS_UNLOCK && wbyte == UNLOCK_KEY2
                         && unl == UNL_GOT1) begin
                unl <= UNL_ARMED;
            end else begin
                unl <= UNL_IDLE;
            end
        end
    end

    // Power-up timer, restarted only by power-on reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i && por_i) begin
            pwrt_cnt <= 22'h000000;
            pwrt_done <= 1'b0;
        end else if (!pwrt_done) begin
            pwrt_cnt <= pwrt_cnt + 22'h000001;
            pwrt_done <= (pwrt_cnt == 22'(PWRT_CNT - 1));
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl.rd <= 1'b0;
            ctrl.wr <= 1'b0;
            ctrl.en <= 1'b0;
            if (por_i) begin
                ctrl.err <= 1'b0;
                ctrl.sel <= 1'b0;
            end else if (ctrl.wr) begin
                ctrl.err <= 1'b1;
            end
        end else begin
            if (bus_wr && avs_address_i == OFS_CTRL) begin
                ctrl.sel <= wbyte[CTRL_PSEL];
                ctrl.en <= wbyte[CTRL_WRITE_ENABLE];
                ctrl.err <= wbyte[CTRL_WERR];
            end
            if (wr_fire) begin
                ctrl.wr <= 1'b0;
            end else if (start_ok) begin
                ctrl.wr <= 1'b1;
            end
            if (ctrl.rd) begin
                ctrl.rd <= 1'b0;
            end else if (bus_wr && avs_address_i == OFS_CTRL && wbyte[CTRL_RD] && !wbyte[CTRL_PSEL]) begin
                ctrl.rd <= 1'b1;
            end
        end
    end

    // Write timer: setup cycles then array write time
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wr_cnt <= CNT_RST;
        end else if (start_ok) begin
            wr_cnt <= 16'(SETUP_CYCLES + WRITE_CYCLES - 1);
        end else if (ctrl.wr && wr_cnt != CNT_RST) begin
            wr_cnt <= wr_cnt - 16'h0001;
        end
    end

    // Address and high data registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            addr_low <= REG_RST;
            addr_high <= REG_RST;
            data_high <= REG_RST;
        end else if (bus_wr) begin
            if (avs_address_i == OFS_ADDRL) begin
                addr_low <= wbyte;
            end else if (avs_address_i == OFS_ADDRH) begin
                addr_high <= wbyte & ADDRH_MASK;
            end else if (avs_address_i == OFS_DATAH) begin
                data_high <= wbyte & DATAH_MASK;
            end
        end
    end

    // Low data register, also loaded by an array read
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            data_low <= REG_RST;
        end else if (ctrl.rd) begin
            data_low <= mem[addr_low];
        end else if (bus_wr && avs_address_i == OFS_DATAL) begin
            data_low <= wbyte;
        end
    end

    // Data array: CPU write has priority over programming path
    always_ff @(posedge clk_i) begin
        if (wr_fire) begin
            mem[addr_low] <= data_low;
        end else if (prog_go && !protect && prog_s2.we) begin
            mem[prog_s2.addr] <= prog_s2.wdata;
        end
    end

    // Two-stage synchronisers for programming pins and fuse
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            prog_s1 <= '0;
            prog_s2 <= '0;
            prog_req_d <= 1'b0;
            fuse_s1 <= 1'b1;
            fuse_s2 <= 1'b1;
        end else begin
            prog_s1 <= prog_i;
            prog_s2 <= prog_s1;
            prog_req_d <= prog_s2.req;
            fuse_s1 <= data_protect_fuse_i;
            fuse_s2 <= fuse_s1;
        end
    end

    // Programming path access, refused while protected
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            prog_rdata_o <= REG_RST;
            prog_denied_o <= 1'b0;
        end else if (prog_go) begin
            prog_denied_o <= protect;
            if (protect) begin
                prog_rdata_o <= REG_RST;
            end else if (!prog_s2.we) begin
                prog_rdata_o <= mem[prog_s2.addr];
            end
        end
    end

    // Sticky interrupt status, set wins over write-one clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_stat <= IRQ_RST;
        end else begin
            irq_stat[IRQ_DONE] <= wr_fire | (irq_stat[IRQ_DONE]
                & ~(bus_wr && avs_address_i == OFS_IRQ_STAT && wbyte[IRQ_DONE]));
            irq_stat[IRQ_DENY] <= (prog_go & protect) | (irq_stat[IRQ_DENY]
                & ~(bus_wr && avs_address_i == OFS_IRQ_STAT && wbyte[IRQ_DENY]));
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_mask <= IRQ_RST;
        end else if (bus_wr && avs_address_i == OFS_IRQ_MASK) begin
            irq_mask <= wbyte[1:0];
        end
    end

    // Level interrupt output
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
        end
    end
endmodule

// File: tb/nvg_guard_properties.sv
`timescale 1ns/100ps
// Port-level checks on the bus handshake, guard windows and reset values
module nvg_guard_props import nvg_pkg::*; #(parameter int PWRT_CNT = 20) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic por_i,
    input wire logic data_protect_fuse_i,
    input wire logic [7:0] prog_rdata_o,
    input wire logic prog_denied_o,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic irq_o
);
    logic [31:0] up_cnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Cycles since the last power-on release, saturating; wide enough for the full timer
    always_ff @(posedge clk_i) begin
        if (!nrst_i && por_i) begin
            up_cnt <= 32'h0000_0000;
        end else if (up_cnt != 32'hFFFF_FFFF) begin
            up_cnt <= up_cnt + 32'h0000_0001;
        end
    end
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_rd_done;
        avs_read_i && !avs_waitrequest_o;
    endsequence
    property p_wait_one; s_req |=> !avs_waitrequest_o; endproperty
    property p_wait_pulse; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    property p_rd_upper; s_rd_done |-> avs_readdata_o[31:8] == 24'h000000; endproperty
    property p_unlock_zero; s_rd_done ##0 avs_address_i == OFS_UNLOCK |-> avs_readdata_o == 32'h0; endproperty
    property p_deny_zero; prog_denied_o |-> prog_rdata_o == 8'h00; endproperty
    property p_deny_fuse; $rose(prog_denied_o) |-> !$past(data_protect_fuse_i, 3); endproperty
    property p_pwrt_quiet; up_cnt < PWRT_CNT + 60 && !prog_denied_o |-> !irq_o; endproperty
    property p_reset_quiet; $rose(nrst_i) |-> avs_waitrequest_o && !irq_o && !prog_denied_o; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest not low after one cycle");
    a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read not zero");
    a_deny_zero: assert property (p_deny_zero) else $error("denied access returned data");
    a_deny_fuse: assert property (p_deny_fuse) else $error("denied while fuse unprotected");
    a_pwrt_quiet: assert property (p_pwrt_quiet) else $error("write completed in power-up window");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not at reset values");
endmodule
bind nvg_guard nvg_guard_props #(.PWRT_CNT(PWRT_CNT)) i_nvg_guard_props (.clk_i(clk_i), .nrst_i(nrst_i),
    .por_i(por_i), .data_protect_fuse_i(data_protect_fuse_i), .prog_rdata_o(prog_rdata_o),
    .prog_denied_o(prog_denied_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o));

// File: tb/eeprom_write_guard_regs_test.sv
`timescale 1ns/100ps
// Self-checking bench for the write guard and its registers
module eeprom_write_guard_regs_test;
    import nvg_pkg::*;
    localparam int PW = 400;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic por_i = 1'b1;
    logic fuse = 1'b1;
    nvg_prog_t prog = '0;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [7:0] prdata;
    logic pden;
    logic [31:0] rdata;
    logic wait_o;
    logic irq;
    int fail_count = 0;
    int samples_checked = 0;
    logic [7:0] mem [256];
    logic [7:0] v;
    logic [7:0] a;
    int i;
    // Clock
    always #10 clk_i = ~clk_i;
    nvg_guard #(.PWRT_CNT(PW)) i_nvg_guard (.clk_i(clk_i), .nrst_i(nrst_i), .por_i(por_i),
        .data_protect_fuse_i(fuse), .prog_i(prog), .prog_rdata_o(prdata), .prog_denied_o(pden),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .irq_o(irq));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [5:0] ad, input logic [7:0] d);
        adr <= ad;
        rd <= ~w;
        wr <= w;
        wd <= {24'h000000, d};
        @(posedge clk_i);
        while (wait_o !== 1'b0) @(posedge clk_i);
        v = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic r8(input logic [5:0] ad, input logic [7:0] e);
        acc(1'b0, ad, 8'h00);
        chk(v, e);
    endtask
    task automatic start(input logic [7:0] k1, input logic [7:0] k2);
        acc(1'b1, OFS_UNLOCK, k1);
        acc(1'b1, OFS_UNLOCK, k2);
        acc(1'b1, OFS_CTRL, 8'h06);
    endtask
    task automatic rst(input logic p);
        nrst_i <= 1'b0;
        por_i <= p;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        por_i <= 1'b0;
    endtask
    // One programming-path access at address a, held for eight cycles
    task automatic pacc(input logic w, input logic [7:0] d);
        prog <= '{1'b1, w, a, d};
        repeat (8) @(posedge clk_i);
        prog <= '0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        conclude();
    end
    // Main sequence
    initial begin
        void'($urandom(51872));
        rst(1'b1);
        for (i = 0; i < 8; i++) r8(6'(i * 4), 8'h00);
        acc(1'b1, OFS_CTRL, 8'h04);
        start(UNLOCK_KEY1, UNLOCK_KEY2);
        r8(OFS_CTRL, 8'h04);
        repeat (PW) @(posedge clk_i);
        r8(OFS_IRQ_STAT, 8'h00);
        start(UNLOCK_KEY2, UNLOCK_KEY1);
        r8(OFS_CTRL, 8'h04);
        acc(1'b1, OFS_UNLOCK, UNLOCK_KEY1);
        r8(OFS_UNLOCK, 8'h00);
        start(UNLOCK_KEY2, UNLOCK_KEY2);
        r8(OFS_CTRL, 8'h04);
        acc(1'b1, OFS_CTRL, 8'h00);
        start(UNLOCK_KEY1, UNLOCK_KEY2);
        r8(OFS_CTRL, 8'h04);
        acc(1'b1, OFS_ADDRH, 8'hFF);
        r8(OFS_ADDRH, ADDRH_MASK);
        acc(1'b1, OFS_DATAH, 8'hFF);
        r8(OFS_DATAH, DATAH_MASK);
        acc(1'b1, 6'h20, 8'hFF);
        r8(6'h20, 8'h00);
        be <= 4'hE;
        acc(1'b1, OFS_ADDRL, 8'hFF);
        be <= 4'hF;
        r8(OFS_ADDRL, 8'h00);
        for (i = 0; i < 4; i++) begin
            a = 8'($urandom);
            mem[a] = 8'($urandom);
            acc(1'b1, OFS_ADDRL, a);
            acc(1'b1, OFS_DATAL, mem[a]);
            acc(1'b1, OFS_IRQ_MASK, {7'h00, i[0]});
            acc(1'b1, OFS_CTRL, 8'h04);
            start(UNLOCK_KEY1, UNLOCK_KEY2);
            r8(OFS_CTRL, 8'h06);
            repeat (SETUP_CYCLES + WRITE_CYCLES) @(posedge clk_i);
            chk({7'h00, irq}, {7'h00, i[0]});
            r8(OFS_CTRL, 8'h04);
            r8(OFS_IRQ_STAT, 8'h01);
            acc(1'b1, OFS_IRQ_STAT, 8'h01);
            @(posedge clk_i);
            chk({7'h00, irq}, 8'h00);
            acc(1'b1, OFS_DATAL, 8'h00);
            acc(1'b1, OFS_CTRL, 8'h01);
            repeat (2) @(posedge clk_i);
            r8(OFS_DATAL, mem[a]);
        end
        pacc(1'b1, 8'h5A);
        mem[a] = 8'h5A;
        pacc(1'b0, 8'h00);
        chk({7'h00, pden}, 8'h00);
        chk(prdata, mem[a]);
        fuse <= 1'b0;
        repeat (8) @(posedge clk_i);
        pacc(1'b0, 8'h00);
        chk({7'h00, pden}, 8'h01);
        chk(prdata, 8'h00);
        pacc(1'b1, 8'hC3);
        r8(OFS_IRQ_STAT, 8'h02);
        acc(1'b1, OFS_CTRL, 8'h01);
        repeat (2) @(posedge clk_i);
        r8(OFS_DATAL, mem[a]);
        acc(1'b1, OFS_CTRL, 8'h04);
        start(UNLOCK_KEY1, UNLOCK_KEY2);
        rst(1'b0);
        r8(OFS_CTRL, 8'h08);
        rst(1'b1);
        r8(OFS_CTRL, 8'h00);
        conclude();
    end
endmodule
